// *** design/dsfo_core.sv ***
// The implementer's own choices: the AHB-Lite slave port and the address map.
`include "dsfo_params.svh"
module dsfo_core
	import dsfo_pkg::*;
#(
	parameter int NUM_OUT  = 4,
	parameter int PWM_BITS = 10
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               hsel,
	input  wire logic [11:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire dsfo_inputs_t       quant,
	output logic      [NUM_OUT-1:0] outTerminal,
	output logic                    frequencyMonitorOut,
	output logic                    analogVoltageMonitorOut,
	output logic                    analogCurrentMonitorOut,
	output logic                    irq
);
	// one select byte per terminal in a 32-bit word, so four terminals at most
	if (NUM_OUT < 1 || NUM_OUT > 4 || PWM_BITS < 4 || PWM_BITS > 16) begin : gBadParam
		$error("bad parameters");
	end

	logic [31:0] ctrl_r, olLvl_r, arv1_r, arv2_r, pidLvl_r, monSel_r, irqSt_r, irqMsk_r, outSel_r, tol_r;
	logic [11:0] aAddr_r;
	logic        aWr_r, aVal_r;
	dsfo_flags_t flags_r, flagsNxt;
	dsfo_ramp_t  ramp;

	// ahb address phase capture
	wire busReq = hsel & hready & htrans[1];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aAddr_r <= 12'h000;
			aWr_r   <= 1'b0;
			aVal_r  <= 1'b0;
		end else begin
			aVal_r  <= busReq;
			aWr_r   <= hwrite;
			aAddr_r <= {haddr[11:2], 2'b00};
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire wrEn = aVal_r & aWr_r;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	// clamp settings to legal range
	wire [15:0] olIn  = (hwdata[15:0] > `DSFO_OLLVL_MAX) ? `DSFO_OLLVL_MAX : hwdata[15:0];
	wire [15:0] pidIn = (hwdata[15:0] > `DSFO_PIDLVL_MAX) ? `DSFO_PIDLVL_MAX : hwdata[15:0];
	// code 3 refused on the two analog outputs
	wire [2:0]  selAm  = (hwdata[6:4] == `DSFO_SRC_DFREQ) ? monSel_r[6:4] : hwdata[6:4];
	wire [2:0]  selAmi = (hwdata[10:8] == `DSFO_SRC_DFREQ) ? monSel_r[10:8] : hwdata[10:8];

	wire [6:0]  flagRise = flagsNxt & ~flags_r;
	wire [31:0] irqSet   = {25'h0, flagRise};
	wire [31:0] irqClr   = (wrEn && hit(aAddr_r, `DSFO_OFF_IRQST)) ? hwdata : 32'h0;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r   <= `DSFO_CTRL_RST;
			olLvl_r  <= {16'h0, `DSFO_OLLVL_RST};
			arv1_r   <= {`DSFO_ARV_RST, `DSFO_ARV_RST};
			arv2_r   <= {`DSFO_ARV_RST, `DSFO_ARV_RST};
			pidLvl_r <= {16'h0, `DSFO_PIDLVL_RST};
			monSel_r <= 32'h0;
			irqSt_r  <= 32'h0;
			irqMsk_r <= 32'h0;
			outSel_r <= {3'h0, `DSFO_OPT_POK, 3'h0, `DSFO_OPT_OD, 3'h0, `DSFO_OPT_OL, 3'h0, `DSFO_OPT_FA1};
			tol_r    <= {16'h0, `DSFO_TOL_RST};
		end else begin
			if (wrEn && hit(aAddr_r, `DSFO_OFF_CTRL))   ctrl_r   <= {31'h0, hwdata[0]};
			if (wrEn && hit(aAddr_r, `DSFO_OFF_OLLVL))  olLvl_r  <= {16'h0, olIn};
			if (wrEn && hit(aAddr_r, `DSFO_OFF_ARV1))   arv1_r   <= hwdata;
			if (wrEn && hit(aAddr_r, `DSFO_OFF_ARV2))   arv2_r   <= hwdata;
			if (wrEn && hit(aAddr_r, `DSFO_OFF_PIDLVL)) pidLvl_r <= {16'h0, pidIn};
			if (wrEn && hit(aAddr_r, `DSFO_OFF_MONSEL)) monSel_r <= {21'h0, selAmi, 1'b0, selAm, 1'b0, hwdata[2:0]};
			if (wrEn && hit(aAddr_r, `DSFO_OFF_IRQMSK)) irqMsk_r <= {25'h0, hwdata[6:0]};
			if (wrEn && hit(aAddr_r, `DSFO_OFF_OUTSEL)) outSel_r <= hwdata;
			if (wrEn && hit(aAddr_r, `DSFO_OFF_TOL))    tol_r    <= {16'h0, hwdata[15:0]};
			irqSt_r <= (irqSt_r & ~irqClr) | irqSet;
		end
	end

	always_comb begin
		hrdata = 32'h0;
		if (aVal_r && !aWr_r) begin
			unique case (aAddr_r)
				`DSFO_OFF_CTRL:   hrdata = ctrl_r;
				`DSFO_OFF_OLLVL:  hrdata = olLvl_r;
				`DSFO_OFF_ARV1:   hrdata = arv1_r;
				`DSFO_OFF_ARV2:   hrdata = arv2_r;
				`DSFO_OFF_PIDLVL: hrdata = pidLvl_r;
				`DSFO_OFF_MONSEL: hrdata = monSel_r;
				`DSFO_OFF_FLAGS:  hrdata = {25'h0, flags_r};
				`DSFO_OFF_IRQST:  hrdata = irqSt_r;
				`DSFO_OFF_IRQMSK: hrdata = irqMsk_r;
				`DSFO_OFF_OUTSEL: hrdata = outSel_r;
				`DSFO_OFF_TOL:    hrdata = tol_r;
				default:          hrdata = 32'h0;
			endcase
		end
	end
	assign irq = |(irqSt_r & irqMsk_r);

	// flag evaluation, every cycle
	assign ramp = quant.accel ? DSFO_RAMP_ACCEL : (quant.decel ? DSFO_RAMP_DECEL : DSFO_RAMP_STEADY);
	function automatic logic nearTo(input logic [15:0] f, input logic [15:0] t, input logic [15:0] tol);
		return ((f >= t) ? (f - t) : (t - f)) <= tol;
	endfunction
	wire [15:0] tol = tol_r[15:0];
	wire olGate = ctrl_r[0] ? (ramp == DSFO_RAMP_STEADY) : (ramp != DSFO_RAMP_STEADY);
	wire ol1 = olGate && (quant.current >= olLvl_r[15:0]);
	wire ol2 = quant.current > olLvl_r[15:0];

	always_comb begin
		flagsNxt = flags_r;
		// hysteretic arrival flags
		unique case (ramp)
			DSFO_RAMP_ACCEL: begin
				if (quant.outFreq >= arv1_r[15:0]) flagsNxt.arrivalFlagFirst = 1'b1;
				if (quant.outFreq >= arv2_r[15:0]) flagsNxt.overFreqFlagTwo = 1'b1;
			end
			DSFO_RAMP_DECEL: begin
				if (quant.outFreq < arv1_r[31:16]) flagsNxt.arrivalFlagFirst = 1'b0;
				if (quant.outFreq < arv2_r[31:16]) flagsNxt.overFreqFlagTwo = 1'b0;
			end
			DSFO_RAMP_STEADY: begin
			end
			default: begin
			end
		endcase
		flagsNxt.atFreqFlagTwo = (quant.accel && nearTo(quant.outFreq, arv2_r[15:0], tol)) ||
			(quant.decel && nearTo(quant.outFreq, arv2_r[31:16], tol));
		flagsNxt.overloadWarnOne = ol1;
		flagsNxt.overloadWarnTwo = ol2;
		flagsNxt.pidDeviationFlag = quant.pidError > pidLvl_r[15:0];
		flagsNxt.positionCompleteFlag = quant.posAtTarget;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) flags_r <= '0;
		else flags_r <= flagsNxt;
	end

	// option code to flag decode
	function automatic logic pick(input logic [4:0] code, input dsfo_flags_t f);
		unique case (code)
			`DSFO_OPT_FA1: return f.arrivalFlagFirst;
			`DSFO_OPT_OL:  return f.overloadWarnOne;
			`DSFO_OPT_OD:  return f.pidDeviationFlag;
			`DSFO_OPT_POK: return f.positionCompleteFlag;
			`DSFO_OPT_FA4: return f.overFreqFlagTwo;
			`DSFO_OPT_FA5: return f.atFreqFlagTwo;
			`DSFO_OPT_OL2: return f.overloadWarnTwo;
			default:       return 1'b0;
		endcase
	endfunction
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : gTerm
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) outTerminal[gi] <= 1'b0;
				else outTerminal[gi] <= pick(outSel_r[gi*8 +: 5], flags_r);
			end
		end
	endgenerate

	// monitor source scaling to pwm duty
	function automatic logic [PWM_BITS-1:0] scale(input logic [15:0] v, input logic [15:0] fs);
		logic [31:0] p;
		p = 32'h0;
		if (fs == 16'h0) return '0;
		if (v >= fs) return '1;
		p = ({16'h0, v} << PWM_BITS) / {16'h0, fs};
		return p[PWM_BITS-1:0];
	endfunction
	function automatic logic [PWM_BITS-1:0] srcDuty(input logic [2:0] s, input dsfo_inputs_t q);
		unique case (s)
			3'h0: return scale(q.outFreq, q.maxFreq);
			3'h1: return scale(q.current, `DSFO_PCT200);
			3'h2: return scale(q.torque, `DSFO_PCT200);
			3'h3: return scale(q.outFreq, q.maxFreq);
			3'h4: return scale(q.voltage, `DSFO_PCT100);
			3'h5: return scale(q.inPower, `DSFO_PCT200);
			3'h6: return scale(q.thermal, `DSFO_PCT100);
			3'h7: return scale(q.rampFreq, q.maxFreq);
			default: return '0;
		endcase
	endfunction
	logic [PWM_BITS-1:0] pwmCnt_r, fmDuty_r, amDuty_r, amiDuty_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwmCnt_r <= '0;
			fmDuty_r <= '0;
			amDuty_r <= '0;
			amiDuty_r <= '0;
			frequencyMonitorOut <= 1'b0;
			analogVoltageMonitorOut <= 1'b0;
			analogCurrentMonitorOut <= 1'b0;
		end else begin
			pwmCnt_r <= PWM_BITS'(pwmCnt_r + 1'b1);
			if (pwmCnt_r == '1) begin
				fmDuty_r <= srcDuty(monSel_r[2:0], quant);
				amDuty_r <= srcDuty(monSel_r[6:4], quant);
				amiDuty_r <= srcDuty(monSel_r[10:8], quant);
			end
			frequencyMonitorOut <= pwmCnt_r < fmDuty_r;
			analogVoltageMonitorOut <= pwmCnt_r < amDuty_r;
			analogCurrentMonitorOut <= pwmCnt_r < amiDuty_r;
		end
	end

	a_pos_flag: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> flags_r.positionCompleteFlag == $past(quant.posAtTarget))
		else $error("position flag wrong");
	a_over2_set: assert property (@(posedge clk) disable iff (sys_rst)
		quant.accel && quant.outFreq >= arv2_r[15:0] |=> flags_r.overFreqFlagTwo)
		else $error("over freq two not set");
	a_over2_clr: assert property (@(posedge clk) disable iff (sys_rst)
		!quant.accel && quant.decel && quant.outFreq < arv2_r[31:16] |=> !flags_r.overFreqFlagTwo)
		else $error("over freq two not cleared");
	a_ol2_level: assert property (@(posedge clk) disable iff (sys_rst)
		quant.current <= olLvl_r[15:0] |=> !flags_r.overloadWarnTwo)
		else $error("overload two high below level");
	a_am_no_dfreq: assert property (@(posedge clk) disable iff (sys_rst)
		monSel_r[6:4] != `DSFO_SRC_DFREQ && monSel_r[10:8] != `DSFO_SRC_DFREQ)
		else $error("digital frequency on analog output");
	a_ol_range: assert property (@(posedge clk) disable iff (sys_rst)
		olLvl_r[15:0] <= `DSFO_OLLVL_MAX)
		else $error("overload level out of range");
	a_pid_flag: assert property (@(posedge clk) disable iff (sys_rst)
		quant.pidError > pidLvl_r[15:0] |=> flags_r.pidDeviationFlag)
		else $error("pid flag missed");
	a_ol_mode: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[0] && ramp != DSFO_RAMP_STEADY |=> !flags_r.overloadWarnOne)
		else $error("overload one outside mode");
	a_irq_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(flags_r.pidDeviationFlag) |-> irqSt_r[1])
		else $error("status bit not set");
	a_arr1_set: assert property (@(posedge clk) disable iff (sys_rst)
		quant.accel && quant.outFreq >= arv1_r[15:0] |=> flags_r.arrivalFlagFirst)
		else $error("arrival one not set");
	a_arr1_clr: assert property (@(posedge clk) disable iff (sys_rst)
		!quant.accel && quant.decel && quant.outFreq < arv1_r[31:16] |=> !flags_r.arrivalFlagFirst)
		else $error("arrival one not cleared");
	a_over2_hold: assert property (@(posedge clk) disable iff (sys_rst)
		ramp == DSFO_RAMP_STEADY |=> flags_r.overFreqFlagTwo == $past(flags_r.overFreqFlagTwo))
		else $error("over freq two moved at steady speed");
	a_at2_accel: assert property (@(posedge clk) disable iff (sys_rst)
		quant.accel && quant.outFreq == arv2_r[15:0] |=> flags_r.atFreqFlagTwo)
		else $error("at freq two missed");
	a_at2_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!quant.accel && !quant.decel |=> !flags_r.atFreqFlagTwo)
		else $error("at freq two high at steady speed");
	a_ol2_high: assert property (@(posedge clk) disable iff (sys_rst)
		quant.current > olLvl_r[15:0] |=> flags_r.overloadWarnTwo)
		else $error("overload two missed");
	a_ol1_set: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[0] && ramp == DSFO_RAMP_STEADY && quant.current >= olLvl_r[15:0] |=> flags_r.overloadWarnOne)
		else $error("overload one missed");
	a_ol1_low: assert property (@(posedge clk) disable iff (sys_rst)
		quant.current < olLvl_r[15:0] |=> !flags_r.overloadWarnOne)
		else $error("overload one high below level");
	a_ol_mode0: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl_r[0] && ramp == DSFO_RAMP_STEADY |=> !flags_r.overloadWarnOne)
		else $error("overload one at steady speed in mode 0");
	a_pid_clear: assert property (@(posedge clk) disable iff (sys_rst)
		quant.pidError <= pidLvl_r[15:0] |=> !flags_r.pidDeviationFlag)
		else $error("pid flag high within level");
	a_pid_range: assert property (@(posedge clk) disable iff (sys_rst)
		pidLvl_r[15:0] <= `DSFO_PIDLVL_MAX)
		else $error("pid level out of range");
	a_term_pos: assert property (@(posedge clk) disable iff (sys_rst)
		outSel_r[4:0] == `DSFO_OPT_POK |=> outTerminal[0] == $past(flags_r.positionCompleteFlag))
		else $error("terminal zero not position flag");
endmodule

// *** design/dsfo_params.svh ***
`ifndef DSFO_PARAMS_SVH
`define DSFO_PARAMS_SVH
`define DSFO_OFF_CTRL      12'h000
`define DSFO_OFF_OLLVL     12'h004
`define DSFO_OFF_ARV1      12'h008
`define DSFO_OFF_ARV2      12'h00c
`define DSFO_OFF_PIDLVL    12'h010
`define DSFO_OFF_MONSEL    12'h014
`define DSFO_OFF_FLAGS     12'h018
`define DSFO_OFF_IRQST     12'h01c
`define DSFO_OFF_IRQMSK    12'h020
`define DSFO_OFF_OUTSEL    12'h024
`define DSFO_OFF_TOL       12'h028
`define DSFO_CTRL_RST      32'h0000_0001
`define DSFO_OLLVL_MAX     16'h07d0
`define DSFO_OLLVL_RST     16'h03e8
`define DSFO_PIDLVL_MAX    16'h03e8
`define DSFO_PIDLVL_RST    16'h001e
`define DSFO_ARV_RST       16'h0000
`define DSFO_TOL_RST       16'h0005
`define DSFO_PCT200        16'h07d0
`define DSFO_PCT100        16'h03e8
`define DSFO_SRC_DFREQ     3'h3
`define DSFO_OPT_OD        5'h04
`define DSFO_OPT_POK       5'h17
`define DSFO_OPT_FA4       5'h18
`define DSFO_OPT_FA5       5'h19
`define DSFO_OPT_OL2       5'h1a
`define DSFO_OPT_OL        5'h03
`define DSFO_OPT_FA1       5'h01
`endif

// *** design/dsfo_pkg.sv ***
package dsfo_pkg;
	typedef struct packed {
		logic [15:0] outFreq;
		logic [15:0] maxFreq;
		logic [15:0] rampFreq;
		logic [15:0] current;
		logic [15:0] torque;
		logic [15:0] voltage;
		logic [15:0] inPower;
		logic [15:0] thermal;
		logic [15:0] pidError;
		logic        accel;
		logic        decel;
		logic        posAtTarget;
	} dsfo_inputs_t;
	typedef struct packed {
		logic arrivalFlagFirst;
		logic overFreqFlagTwo;
		logic atFreqFlagTwo;
		logic overloadWarnOne;
		logic overloadWarnTwo;
		logic pidDeviationFlag;
		logic positionCompleteFlag;
	} dsfo_flags_t;
	typedef enum logic [2:0] {
		DSFO_RAMP_STEADY = 3'b001,
		DSFO_RAMP_ACCEL  = 3'b010,
		DSFO_RAMP_DECEL  = 3'b100
	} dsfo_ramp_t;
endpackage

// *** sim/dsfo_term_reader.sv ***
module dsfo_term_reader #(
	parameter int NUM_OUT = 4
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [NUM_OUT-1:0] outTerminal,
	output logic      [NUM_OUT-1:0] seenTerm
);
	timeunit 1ns;
	timeprecision 1ns;
	// scan of the terminals once per clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seenTerm <= '0;
		end else begin
			seenTerm <= outTerminal;
		end
	end
endmodule

// *** sim/tb.sv ***
`include "dsfo_params.svh"
module tb
	import dsfo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk;
	logic         sys_rst;
	logic         hsel;
	logic [11:0]  haddr;
	logic [1:0]   htrans;
	logic         hwrite;
	logic [2:0]   hsize;
	logic [31:0]  hwdata;
	logic [31:0]  hrdata;
	logic         hreadyout;
	logic         hresp;
	dsfo_inputs_t quant;
	logic [3:0]   outTerminal;
	logic [3:0]   seenTerm;
	logic         fmOut;
	logic         amOut;
	logic         amiOut;
	logic         irq;
	logic [31:0]  rdVal;
	int           n_mismatch;
	int           checked;

	dsfo_core dsfo_core_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .quant(quant), .outTerminal(outTerminal),
		.frequencyMonitorOut(fmOut), .analogVoltageMonitorOut(amOut), .analogCurrentMonitorOut(amiOut), .irq(irq));
	dsfo_term_reader dsfo_term_reader_inst (.clk(clk), .sys_rst(sys_rst), .outTerminal(outTerminal),
		.seenTerm(seenTerm));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] expv, input logic [31:0] got);
		checked++;
		if (got !== expv) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, expv, got);
		end
	endtask

	task automatic cmpNear(input string what, input int expv, input int got);
		checked++;
		if (got < expv - 4 || got > expv + 4) begin
			n_mismatch++;
			$display("unexpected %s: expected %0d seen %0d", what, expv, got);
		end
	endtask

	task automatic busXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdVal = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		busXfer(1'b1, a, d);
	endtask

	task automatic chkReg(input string what, input logic [11:0] a, input logic [31:0] e);
		busXfer(1'b0, a, 32'h0);
		cmp(what, e, rdVal);
		cmp({what, " hresp"}, 32'h0, {31'h0, hresp});
	endtask

	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic testResetValues;
		chkReg("ctrl", `DSFO_OFF_CTRL, 32'h0000_0001);
		chkReg("ollvl", `DSFO_OFF_OLLVL, 32'h0000_03e8);
		chkReg("arv1", `DSFO_OFF_ARV1, 32'h0000_0000);
		chkReg("arv2", `DSFO_OFF_ARV2, 32'h0000_0000);
		chkReg("pidlvl", `DSFO_OFF_PIDLVL, 32'h0000_001e);
		chkReg("outsel", `DSFO_OFF_OUTSEL, 32'h1704_0301);
		chkReg("tol", `DSFO_OFF_TOL, 32'h0000_0005);
		wr(12'h030, 32'hffff_ffff);
		chkReg("unmapped", 12'h030, 32'h0000_0000);
		wr(`DSFO_OFF_PIDLVL, 32'h0000_07d0);
		chkReg("pidlvl clamp", `DSFO_OFF_PIDLVL, 32'h0000_03e8);
		wr(`DSFO_OFF_OLLVL, 32'h0000_0bb8);
		chkReg("ollvl clamp", `DSFO_OFF_OLLVL, 32'h0000_07d0);
	endtask

	task automatic testDefaultFlags;
		wr(`DSFO_OFF_OLLVL, 32'h0000_03e8);
		wr(`DSFO_OFF_PIDLVL, 32'h0000_001e);
		quant.current     <= 16'h03e8;
		quant.pidError    <= 16'h001f;
		quant.posAtTarget <= 1'b1;
		settle();
		cmp("terminals on", 32'h7, {29'h0, seenTerm[3:1]});
		quant.current     <= 16'h03e7;
		quant.pidError    <= 16'h001e;
		quant.posAtTarget <= 1'b0;
		settle();
		cmp("terminals off", 32'h0, {29'h0, seenTerm[3:1]});
		quant.current <= 16'h03e8;
		quant.accel   <= 1'b1;
		settle();
		cmp("overload mode 1", 32'h0, {29'h0, seenTerm[3:1]});
		wr(`DSFO_OFF_CTRL, 32'h0000_0000);
		settle();
		cmp("overload mode 0", 32'h1, {29'h0, seenTerm[3:1]});
	endtask

	task automatic testSecondSet;
		logic [15:0] fq [5] = '{16'h01ee, 16'h01f4, 16'h01fe, 16'h012e, 16'h0122};
		logic [15:0] cu [5] = '{16'h03e8, 16'h03e8, 16'h03e9, 16'h03e7, 16'h03e9};
		logic [1:0]  dr [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
		logic [2:0]  ex [5] = '{3'h0, 3'h3, 3'h5, 3'h3, 3'h4};
		wr(`DSFO_OFF_OUTSEL, 32'h171a_1918);
		wr(`DSFO_OFF_ARV2, 32'h012c_01f4);
		quant.outFreq <= 16'h0000;
		quant.accel   <= 1'b0;
		quant.decel   <= 1'b1;
		settle();
		cmp("second set clear", 32'h0, {31'h0, seenTerm[0]});
		for (int i = 0; i < 5; i++) begin
			quant.outFreq <= fq[i];
			quant.current <= cu[i];
			quant.accel   <= dr[i][0];
			quant.decel   <= dr[i][1];
			settle();
			cmp("second set", {29'h0, ex[i]}, {29'h0, seenTerm[2:0]});
		end
	endtask

	task automatic testIrq;
		wr(`DSFO_OFF_IRQST, 32'h0000_007f);
		wr(`DSFO_OFF_IRQMSK, 32'h0000_0000);
		quant.posAtTarget <= 1'b1;
		settle();
		busXfer(1'b0, `DSFO_OFF_FLAGS, 32'h0);
		cmp("flag bit", 32'h1, {31'h0, rdVal[0]});
		chkReg("status", `DSFO_OFF_IRQST, 32'h0000_0001);
		cmp("irq masked", 32'h0, {31'h0, irq});
		wr(`DSFO_OFF_IRQMSK, 32'h0000_0001);
		@(posedge clk);
		cmp("irq on", 32'h1, {31'h0, irq});
		quant.posAtTarget <= 1'b0;
		wr(`DSFO_OFF_IRQST, 32'h0000_0001);
		@(posedge clk);
		cmp("irq cleared", 32'h0, {31'h0, irq});
		chkReg("status clr", `DSFO_OFF_IRQST, 32'h0000_0000);
	endtask

	task automatic testMonitor;
		int duty [8] = '{128, 256, 384, 128, 640, 768, 896, 512};
		int nFm;
		int nAm;
		int nAmi;
		logic [31:0] old;
		busXfer(1'b0, `DSFO_OFF_MONSEL, 32'h0);
		old = rdVal;
		wr(`DSFO_OFF_MONSEL, 32'h0000_0333);
		chkReg("monsel code 3", `DSFO_OFF_MONSEL, (old & 32'hffff_fff8) | 32'h3);
		quant.maxFreq  <= 16'h0fa0;
		quant.outFreq  <= 16'h01f4;
		quant.current  <= 16'h01f4;
		quant.torque   <= 16'h02ee;
		quant.voltage  <= 16'h0271;
		quant.inPower  <= 16'h05dc;
		quant.thermal  <= 16'h036b;
		quant.rampFreq <= 16'h07d0;
		for (int c = 0; c < 8; c++) begin
			wr(`DSFO_OFF_MONSEL, {21'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]});
			repeat (1024) @(posedge clk);
			nFm = 0;
			nAm = 0;
			nAmi = 0;
			repeat (1024) begin
				@(posedge clk);
				if (fmOut === 1'b1) nFm++;
				if (amOut === 1'b1) nAm++;
				if (amiOut === 1'b1) nAmi++;
			end
			cmpNear("fm duty", duty[c], nFm);
			cmpNear("am duty", (c == 3) ? duty[2] : duty[c], nAm);
			cmpNear("ami duty", (c == 3) ? duty[2] : duty[c], nAmi);
		end
	endtask

	initial begin
		#4000000;
		n_mismatch++;
		conclude();
	end

	initial begin
		n_mismatch = 0;
		checked = 0;
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		quant = '0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		testResetValues();
		testDefaultFlags();
		testSecondSet();
		testIrq();
		testMonitor();
		conclude();
	end
endmodule
